// File: src/chop_gen.sv
/*
 * High-frequency chopping carrier for pulse-transformer gate drives.
 * Assumes the instruction-rate clock and a synchronous low reset.
 */
`timescale 1ns/1ns
module chop_gen
    import pwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Setting
    input wire logic [CHOP_W-1:0] chop_period,
    // Carrier
    output logic chop
);
    logic [CHOP_W-1:0] div;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            div <= '0;
            chop <= 1'b0;
        end else if (div >= chop_period) begin
            div <= '0;
            chop <= !chop;
        end else begin
            div <= div + CHOP_W'(1);
        end
    end

endmodule

// File: src/pwm_phase_timer.sv
/*
 * Centre-based edge timing of one phase with dead time and pulse deletion.
 * Assumes the half-period counter and the latched settings of the caller.
 */
`timescale 1ns/1ns
module pwm_phase_timer
    import pwm_pkg::*;
(
    // Timing base
    input wire logic [CNT_W-1:0] count,
    input wire logic second_half,
    // Latched settings
    input wire logic [CNT_W-1:0] half_period,
    input wire logic [CNT_W-1:0] duty,
    input wire logic [DT_W-1:0] dead_time,
    input wire logic [CNT_W-1:0] pulse_limit,
    // Raw pair
    output logic high_raw,
    output logic low_raw
);
    logic [WIDE_W-1:0] t;
    logic [WIDE_W-1:0] tm;
    logic [WIDE_W-1:0] d;
    logic [WIDE_W-1:0] dt;
    logic [WIDE_W-1:0] pd;
    logic [WIDE_W-1:0] off_len;
    logic high_narrow;
    logic low_narrow;

    assign t = WIDE_W'(count);
    assign tm = WIDE_W'(half_period);
    assign d = (WIDE_W'(duty) > tm) ? tm : WIDE_W'(duty);
    assign dt = WIDE_W'(dead_time) << DT_SHIFT;
    assign pd = WIDE_W'(pulse_limit);
    assign off_len = tm - d;
    assign high_narrow = d < (dt + pd);
    assign low_narrow = off_len < (dt + pd);

    always_comb begin
        if (second_half) begin
            high_raw = (t < d) && !high_narrow;
            low_raw = (t >= d + dt) && !low_narrow;
        end else begin
            high_raw = (t >= off_len + dt) && !high_narrow;
            low_raw = (t < off_len) && !low_narrow;
        end
    end

endmodule

// File: src/pwm_pkg.sv
/*
 * Shared types and constants of the three-phase PWM controller.
 * Assumes one clock at the instruction rate and a synchronous low reset.
 */
package pwm_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int NUM_PHASES = 3;
    localparam int NUM_OUTS = 6;
    localparam int CNT_W = 16;
    localparam int DT_W = 10;
    localparam int CHOP_W = 8;
    localparam int WIDE_W = 18;

    // ****************************************
    // Bit positions and reset values
    // ****************************************
    localparam int MODE_DOUBLE_BIT = 6;
    localparam int STAT_TRIP_BIT = 0;
    localparam int STAT_HALF_BIT = 3;
    localparam logic [7:0] SYNC_WIDTH_RESET = 8'h27;
    localparam logic [CNT_W-1:0] HALF_PERIOD_RESET = 16'hffff;
    localparam int DT_SHIFT = 1;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [CNT_W-1:0] half_period_count;
        logic [DT_W-1:0] dead_time_count;
        logic [CNT_W-1:0] narrow_pulse_limit;
        logic [7:0] sync_width;
    } pwm_cfg_t;

    typedef struct packed {
        logic [NUM_PHASES-1:0][CNT_W-1:0] duty;
    } duty_set_t;

    typedef struct packed {
        logic [NUM_PHASES-1:0] crossover;
        logic [NUM_OUTS-1:0] enable;
    } route_t;

    typedef struct packed {
        logic [CHOP_W-1:0] chop_period;
        logic chop_high_en;
        logic chop_low_en;
    } chop_t;

endpackage

// File: src/three_phase_pwm_controller.sv
/*
 * Three-phase centre-based PWM controller: timing unit, output routing,
 * chopping, sync pulse generation and shutdown control.
 * Assumes settings arrive as plain ports synchronous to clk_sys.
 */
// Summary of operation
// - Six active-high outputs in three pairs
// - Period, dead time, pulse deletion are programmable
// - One duty value per phase, independent
// - Each output has its own enable
// - Crossover swaps high and low of pair
// - Eight-bit field sets chopping frequency
// - Separate chop enables for high, low
// - Single mode loads once per period
// - Double mode also loads at midpoint
// - Mode bit six selects single or double
// - Sync pulse at every period start
// - Double mode adds midpoint sync pulse
// - Sync width programmable by its setting
// - Trip low forces all outputs off
// - Trip gating uses no clocked logic
// - Software trip turns all outputs off
// - Status shows trip level, and half in double mode
// - Three shutdown sources reset timing unit
// - Runs at the instruction clock rate
// - Sync and shutdown events raise interrupts
// - Sixteen-bit timing unit, centre-based pairs
// - Duty values are sixteen bits wide
// - Period value counts half a period
// - Dead time is value times two ticks
// - Sync lasts width plus one, reset 0x27
// - Half bit clear first, set second in double mode; always clear in single mode
`timescale 1ns/1ns
module three_phase_pwm_controller
    import pwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Settings
    input wire pwm_pkg::pwm_cfg_t cfg,
    input wire pwm_pkg::duty_set_t duty_in,
    input wire pwm_pkg::route_t output_route_enable,
    input wire pwm_pkg::chop_t chop_control,
    input wire logic [7:0] mode_control,
    // Shutdown
    input wire logic trip_in_n,
    input wire logic analog_trip,
    input wire logic software_trip,
    input wire logic shutdown_clear,
    // Gate drives
    output logic phase_a_high_out,
    output logic phase_a_low_out,
    output logic phase_b_high_out,
    output logic phase_b_low_out,
    output logic phase_c_high_out,
    output logic phase_c_low_out,
    // Sync, status, interrupts
    output logic sync_pulse,
    output logic [7:0] system_status,
    output logic irq_sync,
    output logic irq_trip
);
    import pwm_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    pwm_cfg_t cfg_s;
    duty_set_t duty_s;
    route_t route_s;
    logic [CNT_W-1:0] count;
    logic second_half;
    logic start_pending;
    logic last_tick;
    logic load_now;
    logic double_mode;
    logic [8:0] sync_left;
    logic shut;
    logic shut_req;
    logic [NUM_OUTS-1:0] raw;
    logic [NUM_OUTS-1:0] routed;
    logic [NUM_OUTS-1:0] gate_q;
    logic chop;

    // ****************************************
    // Shutdown control
    // ****************************************
    assign shut_req = !trip_in_n || analog_trip || software_trip;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            shut <= 1'b0;
        end else if (shut_req) begin
            shut <= 1'b1;
        end else if (shutdown_clear) begin
            shut <= 1'b0;
        end
    end

    // ****************************************
    // Half-period counter
    // ****************************************
    assign double_mode = mode_control[MODE_DOUBLE_BIT];
    assign last_tick = (17'(count) + 17'd1) >= 17'(cfg_s.half_period_count);
    assign load_now = start_pending || (last_tick && (second_half || double_mode));

    always_ff @(posedge clk_sys) begin
        if (!nrst || shut) begin
            count <= '0;
            second_half <= 1'b0;
            start_pending <= 1'b1;
        end else if (start_pending) begin
            start_pending <= 1'b0;
        end else if (last_tick) begin
            count <= '0;
            second_half <= !second_half;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

    // ****************************************
    // Shadow settings
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg_s.half_period_count <= HALF_PERIOD_RESET;
            cfg_s.dead_time_count <= '0;
            cfg_s.narrow_pulse_limit <= '0;
            cfg_s.sync_width <= SYNC_WIDTH_RESET;
            duty_s <= '0;
            route_s <= '0;
        end else if (load_now) begin
            cfg_s <= cfg;
            duty_s <= duty_in;
            route_s <= output_route_enable;
        end
    end

    // ****************************************
    // Sync pulse
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst || shut) begin
            sync_left <= '0;
            sync_pulse <= 1'b0;
        end else if (load_now) begin
            sync_left <= 9'(cfg.sync_width);
            sync_pulse <= 1'b1;
        end else if (sync_left != '0) begin
            sync_left <= sync_left - 9'd1;
        end else begin
            sync_pulse <= 1'b0;
        end
    end

    // ****************************************
    // Interrupts and status
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_sync <= 1'b0;
            irq_trip <= 1'b0;
        end else begin
            irq_sync <= load_now && !shut;
            irq_trip <= shut_req && !shut;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            system_status <= '0;
        end else begin
            system_status <= '0;
            system_status[STAT_TRIP_BIT] <= trip_in_n;
            system_status[STAT_HALF_BIT] <= double_mode && second_half;
        end
    end

    // ****************************************
    // Timing unit, routing and chopping
    // ****************************************
    chop_gen u_chop (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .chop_period(chop_control.chop_period),
        .chop(chop)
    );

    generate
        for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
            pwm_phase_timer u_timer (
                .count(count),
                .second_half(second_half),
                .half_period(cfg_s.half_period_count),
                .duty(duty_s.duty[p]),
                .dead_time(cfg_s.dead_time_count),
                .pulse_limit(cfg_s.narrow_pulse_limit),
                .high_raw(raw[2*p]),
                .low_raw(raw[2*p+1])
            );
            // Crossover swaps the pair, then enables and chopping apply
            assign routed[2*p] = route_s.crossover[p] ? raw[2*p+1] : raw[2*p];
            assign routed[2*p+1] = route_s.crossover[p] ? raw[2*p] : raw[2*p+1];

            always_ff @(posedge clk_sys) begin
                if (!nrst || shut || start_pending) begin
                    gate_q[2*p] <= 1'b0;
                    gate_q[2*p+1] <= 1'b0;
                end else begin
                    gate_q[2*p] <= routed[2*p] && route_s.enable[2*p]
                        && (chop || !chop_control.chop_high_en);
                    gate_q[2*p+1] <= routed[2*p+1] && route_s.enable[2*p+1]
                        && (chop || !chop_control.chop_low_en);
                end
            end
        end
    endgenerate

    // ****************************************
    // Output gating by the trip pin
    // ****************************************
    // Combinational so that a stopped clock still turns the drives off
    assign phase_a_high_out = gate_q[0] && trip_in_n;
    assign phase_a_low_out = gate_q[1] && trip_in_n;
    assign phase_b_high_out = gate_q[2] && trip_in_n;
    assign phase_b_low_out = gate_q[3] && trip_in_n;
    assign phase_c_high_out = gate_q[4] && trip_in_n;
    assign phase_c_low_out = gate_q[5] && trip_in_n;

    // ****************************************
    // Assertions
    // ****************************************
    logic [8:0] sync_len;
    logic [8:0] sync_len_want;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync_len <= '0;
            sync_len_want <= '0;
        end else if (load_now && !shut) begin
            sync_len <= 9'd1;
            sync_len_want <= 9'(cfg.sync_width) + 9'd1;
        end else if (sync_pulse) begin
            sync_len <= sync_len + 9'd1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence shut_event;
        shut_req && !shut;
    endsequence

    sequence mid_crossing;
        last_tick && !second_half && !start_pending;
    endsequence

    sync_width_a: assert property ($fell(sync_pulse) && !$past(shut)
        |-> $past(sync_len) == $past(sync_len_want))
        else $error("sync pulse width differs from setting plus one");

    trip_off_a: assert property (!trip_in_n
        |-> !(phase_a_high_out || phase_a_low_out || phase_b_high_out
            || phase_b_low_out || phase_c_high_out || phase_c_low_out))
        else $error("drive active while trip pin low");

    shut_entry_a: assert property (shut_event |=> shut && irq_trip ##1 gate_q == '0)
        else $error("shutdown not taken or outputs not off");

    shut_hold_a: assert property (shut && (shut_req || !shutdown_clear) |=> shut)
        else $error("shutdown released without clear");

    half_status_a: assert property (double_mode && $past(double_mode)
        |-> system_status[STAT_HALF_BIT] == $past(second_half))
        else $error("half status bit wrong");

    trip_status_a: assert property ($past(nrst)
        |-> system_status[STAT_TRIP_BIT] == $past(trip_in_n))
        else $error("trip status does not follow pin");

    mid_single_a: assert property (mid_crossing and (!double_mode && !shut)
        |=> !irq_sync)
        else $error("single mode loaded at midpoint");

    mid_double_a: assert property (mid_crossing and (double_mode && !shut)
        |=> irq_sync && sync_pulse)
        else $error("double mode missed midpoint sync");

    enable_off_a: assert property (!route_s.enable[0] && !load_now
        |=> !gate_q[0])
        else $error("disabled output driven");

    pair_overlap_a: assert property (!route_s.crossover[0] && !load_now
        |=> !(gate_q[0] && gate_q[1]))
        else $error("both drives of a pair active");

    sync_start_a: assert property (load_now && !shut |=> sync_pulse && irq_sync)
        else $error("load point without sync pulse");

    shadow_load_a: assert property (load_now && !shut |=> duty_s == $past(duty_in))
        else $error("duty not taken at load point");

    shadow_hold_a: assert property (!load_now |=> $stable(duty_s))
        else $error("duty changed between load points");

    shut_gates_a: assert property (shut |=> gate_q == '0)
        else $error("gate flops active during shutdown");

    chop_high_a: assert property (chop_control.chop_high_en && !chop
        |=> !gate_q[0])
        else $error("high drive on while chop carrier low");

    chop_low_a: assert property (chop_control.chop_low_en && !chop
        |=> !gate_q[1])
        else $error("low drive on while chop carrier low");

    cross_route_a: assert property (route_s.crossover[0] && route_s.enable[0]
        && !chop_control.chop_high_en && !shut && !start_pending && !load_now
        |=> gate_q[0] == $past(raw[1]))
        else $error("crossover did not route low signal to high drive");

    half_toggle_a: assert property (last_tick && !start_pending && !shut
        |=> second_half != $past(second_half))
        else $error("half not toggled at end of half period");

    half_single_a: assert property (!double_mode |=> !system_status[STAT_HALF_BIT])
        else $error("half status set in single mode");

endmodule

// File: verification/gate_drive_model.sv
/*
 * Inverter gate-drive model: counts on-cycles of each switch, flags shoot-through.
 * Assumes the six drives sampled on the rising edge of clk_sys.
 */
`timescale 1ns/1ns
module gate_drive_model
    import pwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic clear_cnt,
    // Drives, bit 2p high side, 2p+1 low side
    input wire logic [pwm_pkg::NUM_OUTS-1:0] drive,
    // Observations
    output logic [pwm_pkg::NUM_OUTS-1:0][7:0] on_cycles,
    output logic overlap
);
    // ****************************************
    // On-time counters
    // ****************************************
    always_ff @(posedge clk_sys) begin
        for (int k = 0; k < NUM_OUTS; k++) begin
            on_cycles[k] <= clear_cnt ? 8'h00 : on_cycles[k] + {7'h00, drive[k]};
        end
    end

    // ****************************************
    // Both switches of one leg on
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            overlap <= 1'b0;
        end else begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                if (drive[2*p] && drive[2*p+1]) begin
                    overlap <= 1'b1;
                end
            end
        end
    end
endmodule

// File: verification/testbench.sv
/*
 * Self-checking bench of the three-phase PWM controller.
 * Assumes a 20-tick half period and measures whole 40-cycle periods.
 */
`timescale 1ns/1ns
module testbench;
    import pwm_pkg::*;
    logic clk_sys, nrst, trip_in_n, analog_trip, software_trip, shutdown_clear, clear_cnt;
    pwm_cfg_t cfg;
    duty_set_t duty_in;
    route_t route;
    chop_t chop;
    logic [7:0] mode_control, system_status;
    logic [5:0] drv;
    logic [5:0][7:0] on_cycles;
    logic sync_pulse, irq_sync, irq_trip, overlap;
    logic [7:0] hi_exp [3] = '{8'h0a, 8'h10, 8'h18};
    int err_total, check_count, cyc, sync_hi, sync_ev, half_hi, n;

    three_phase_pwm_controller u_dut (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg),
        .duty_in(duty_in), .output_route_enable(route), .chop_control(chop),
        .mode_control(mode_control), .trip_in_n(trip_in_n), .analog_trip(analog_trip),
        .software_trip(software_trip), .shutdown_clear(shutdown_clear),
        .phase_a_high_out(drv[0]), .phase_a_low_out(drv[1]), .phase_b_high_out(drv[2]),
        .phase_b_low_out(drv[3]), .phase_c_high_out(drv[4]), .phase_c_low_out(drv[5]),
        .sync_pulse(sync_pulse), .system_status(system_status), .irq_sync(irq_sync),
        .irq_trip(irq_trip));
    gate_drive_model u_gate (.clk_sys(clk_sys), .nrst(nrst), .clear_cnt(clear_cnt),
        .drive(drv), .on_cycles(on_cycles), .overlap(overlap));

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic stop_test;
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic chk_pair(input int p, input logic [7:0] h, input logic [7:0] l);
        chk(on_cycles[2*p], h);
        chk(on_cycles[2*p+1], l);
    endtask
    task automatic measure;
        repeat (80) @(posedge clk_sys);
        #5 clear_cnt = 1'b1;
        @(posedge clk_sys);
        #5 clear_cnt = 1'b0;
        sync_hi = 0;
        sync_ev = 0;
        half_hi = 0;
        repeat (40) begin
            @(posedge clk_sys);
            #5;
            if (sync_pulse === 1'b1) sync_hi++;
            if (irq_sync === 1'b1) sync_ev++;
            if (system_status[STAT_HALF_BIT] === 1'b1) half_hi++;
        end
    endtask
    task automatic set_req(input int src, input logic v);
        case (src)
            0: trip_in_n = ~v;
            1: analog_trip = v;
            default: software_trip = v;
        endcase
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_base;
        measure();
        for (int p = 0; p < 3; p++) chk_pair(p, hi_exp[p], 8'd40 - hi_exp[p]);
        chk(sync_hi, 8'd4);
        chk(sync_ev, 8'd1);
        chk(half_hi, 8'd0);
        chk(system_status[STAT_TRIP_BIT], 1'b1);
    endtask
    task automatic t_shape;
        cfg.dead_time_count = 10'd2;
        measure();
        chk_pair(0, 8'd6, 8'd26);
        cfg.dead_time_count = 10'd0;
        cfg.narrow_pulse_limit = 16'd6;
        measure();
        chk_pair(0, 8'd0, 8'd30);
        chk_pair(1, 8'd16, 8'd24);
        cfg.narrow_pulse_limit = 16'd0;
    endtask
    task automatic t_route;
        for (int k = 0; k < 6; k++) begin
            route.enable = ~(6'h01 << k);
            measure();
            chk(on_cycles[k], 8'd0);
            chk(on_cycles[k^1], k[0] ? hi_exp[k/2] : 8'd40 - hi_exp[k/2]);
        end
        route.enable = 6'h3f;
        for (int p = 0; p < 3; p++) begin
            route.crossover = 3'h1 << p;
            measure();
            chk_pair(p, 8'd40 - hi_exp[p], hi_exp[p]);
        end
        route.crossover = 3'h0;
    endtask
    task automatic t_chop;
        chop = '{chop_period: 8'h00, chop_high_en: 1'b1, chop_low_en: 1'b0};
        measure();
        chk_pair(0, 8'd5, 8'd30);
        chop = '{chop_period: 8'h00, chop_high_en: 1'b0, chop_low_en: 1'b1};
        measure();
        chk_pair(0, 8'd10, 8'd15);
        chop = '{chop_period: 8'h00, chop_high_en: 1'b0, chop_low_en: 1'b0};
    endtask
    task automatic t_double;
        mode_control = 8'h40;
        measure();
        chk(sync_ev, 8'd2);
        chk(sync_hi, 8'd8);
        chk(half_hi, 8'd20);
        chk_pair(0, 8'd10, 8'd30);
        mode_control = 8'hbf;
    endtask
    task automatic t_trip(input int src);
        set_req(src, 1'b1);
        #1;
        if (src == 0) chk({2'b00, drv}, 8'h00);
        n = 0;
        shutdown_clear = 1'b1;
        repeat (3) begin
            @(posedge clk_sys);
            #5;
            if (irq_trip === 1'b1) n++;
        end
        shutdown_clear = 1'b0;
        chk(n, 8'd1);
        if (src == 0) chk(system_status[STAT_TRIP_BIT], 1'b0);
        set_req(src, 1'b0);
        measure();
        for (int k = 0; k < 6; k++) chk(on_cycles[k], 8'd0);
        chk(sync_ev, 8'd0);
        shutdown_clear = 1'b1;
        @(posedge clk_sys);
        #5 shutdown_clear = 1'b0;
        measure();
        chk_pair(0, 8'd10, 8'd30);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        trip_in_n = 1'b1;
        analog_trip = 1'b0;
        software_trip = 1'b0;
        shutdown_clear = 1'b0;
        clear_cnt = 1'b0;
        cfg = '{half_period_count: 16'd20, dead_time_count: 10'd0,
                narrow_pulse_limit: 16'd0, sync_width: 8'd3};
        duty_in.duty = {16'd12, 16'd8, 16'd5};
        route = '{crossover: 3'h0, enable: 6'h3f};
        chop = '{chop_period: 8'h00, chop_high_en: 1'b0, chop_low_en: 1'b0};
        mode_control = 8'hbf;
        repeat (6) @(posedge clk_sys);
        #5;
        chk({sync_pulse, system_status[6:0]}, 8'h00);
        nrst = 1'b1;
        t_base();
        t_shape();
        t_route();
        t_chop();
        t_double();
        for (int s = 0; s < 3; s++) t_trip(s);
        chk(overlap, 1'b0);
        stop_test();
    end
endmodule
